/* common/rtc_pkg.sv */
// types of the rotary touch configuration bank
// assumes rtc_regs.svh supplies the numeric constants
`default_nettype none
package rtc_pkg;

	// register bank and output state of the top module
	typedef struct packed {
		logic       click_en;  // touch_click_enable
		logic       rel_en;    // release_report_enable
		logic       touch_en;  // touch_report_enable
		logic       rot_en;    // rotary_function_enable
		logic [2:0] sens;      // touch sensitivity code
		logic [4:0] tick;      // tick period field
		logic [5:0] intv;      // acquisition interval field
		logic [2:0] sound;     // sounder configuration bits
		logic [7:0] rdata;     // read answer
		logic       rvalid;    // read answer strobe
		logic       push;      // fifo push strobe
		logic [7:0] code;      // fifo event code
		logic       click;     // sounder click request
		logic [2:0] level;     // effective sensitivity code
	} rtc_state_t;

	// timebase counters
	typedef struct packed {
		logic [17:0] ms_cnt;   // clock cycles within the current ms
		logic [5:0]  ms_tick;  // ms within the current tick
		logic [5:0]  ticks;    // ticks within the current acquisition
		logic        tick;     // tick strobe
		logic        acq;      // acquisition strobe
	} rtc_tb_state_t;

endpackage
`default_nettype wire

/* common/rtc_regs.svh */
// register offsets, field positions, reset values and timing counts of the
// rotary touch configuration bank; assumes a byte-wide register port
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// register offsets (byte addresses on the register port)
`define RTC_ADDR_POSITION   8'h02
`define RTC_ADDR_SETUP      8'h03
`define RTC_ADDR_SENS       8'h04
`define RTC_ADDR_TICK       8'h05
`define RTC_ADDR_INTERVAL   8'h06
`define RTC_ADDR_SOUNDER    8'h07

// rotary setup field positions
`define RTC_SETUP_ENABLE    0
`define RTC_SETUP_TOUCH     2
`define RTC_SETUP_RELEASE   3
`define RTC_SETUP_CLICK     7

// reset values
`define RTC_RST_SETUP       4'h0
`define RTC_RST_SENS        3'h0
`define RTC_RST_TICK        5'h00
`define RTC_RST_INTERVAL    6'h00
`define RTC_RST_SOUNDER     3'h0

// fifo event codes
`define RTC_CODE_TOUCH_HI   4'h1
`define RTC_CODE_RELEASE    8'h0F

// sensitivity code that has no level of its own, and the level it maps to
`define RTC_SENS_UNDEF      3'h7
`define RTC_SENS_TOP        3'h6

// timing: clock period and one millisecond, both in ns
`define RTC_CLK_NS          5
`define RTC_MS_NS           1000000
`define RTC_CYC_PER_MS      (`RTC_MS_NS / `RTC_CLK_NS)
// tick period is this many ms plus the tick field
`define RTC_TICK_BASE_MS    5

`endif

/* dv/rtc_config_regs_tb.sv */
// self-checking bench of the rotary touch configuration bank
// assumes rtc_host_model drives every bank input on the rising edge
`timescale 1ns/100ps
`default_nettype none
module rtc_config_regs_tb;
	localparam int CPM = 4;  // short ms keeps tick runs brief
	logic       clock, resetn, reg_wr, reg_rd, reg_rvalid, touch_evt, release_evt, touch_held, v;
	logic       fifo_push, click_req, rotary_on, tick_pulse, acq_pulse;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_code, d, m;
	logic [3:0] touch_pos;
	logic [2:0] sens_level;
	int         err_total, compares, seed, cyc, mreg[8], i, n, a;
	logic [7:0] addrs[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h20};  // 20 is unmapped
	logic [7:0] modes[6] = '{8'h8D, 8'h01, 8'h8C, 8'h05, 8'h09, 8'h81};

	rtc_config_regs #(.CYC_PER_MS(CPM)) DUT (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.touch_evt(touch_evt), .release_evt(release_evt), .touch_held(touch_held), .touch_pos(touch_pos),
		.fifo_push(fifo_push), .fifo_code(fifo_code), .click_req(click_req), .sens_level(sens_level),
		.rotary_on(rotary_on), .tick_pulse(tick_pulse), .acq_pulse(acq_pulse));
	rtc_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .touch_evt(touch_evt),
		.release_evt(release_evt), .touch_held(touch_held), .touch_pos(touch_pos));

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	// bank model: what a read of address a returns
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h02: return (mreg[3][0] && touch_held) ? {4'h1, touch_pos} : 8'h00;
			8'h03: return 8'(mreg[3] & 8'h8D);
			8'h04: return 8'(mreg[4] & 8'h07);
			8'h05: return 8'(mreg[5] & 8'h1F);
			8'h06: return 8'(mreg[6] & 8'h3F);
			8'h07: return 8'(mreg[7] & 8'h07);
			default: return 8'h00;
		endcase
	endfunction
	// byte result compare
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// cycle count compare
	task automatic chk_n(input string what, input int exp, input int got);
		compares++;
		if (got != exp) begin
			err_total++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a);
		host.rd(a, d, v);
		chk("rvalid", 8'h01, {7'h00, v});
		chk("rdata", exp_rd(a), d);
	endtask
	// cycles between two pulses of tick (acq=0) or acquisition (acq=1)
	// pulses are looked at mid-cycle, where they are settled
	task automatic gap(input logic acq, output int g);
		int k;
		@(negedge clock);
		for (k = 0; k < 2000 && (acq ? acq_pulse : tick_pulse) !== 1'b1; k++) @(negedge clock);
		@(negedge clock);
		for (g = 1; g < 2000 && (acq ? acq_pulse : tick_pulse) !== 1'b1; g++) @(negedge clock);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		err_total = 0;
		compares = 0;
		cyc = 0;
		seed = 32'hEF68;
		resetn = 1'b0;
		foreach (mreg[k]) mreg[k] = 0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		for (i = 0; i < 7; i++) rd_chk(addrs[i]);
		$display("reset reads done");
		// random bytes into every place, undefined bits must drop
		for (i = 0; i < 41; i++) begin
			a = (i == 40) ? 4 : addrs[$unsigned($random(seed)) % 7];
			m = (i == 40) ? 8'hFF : 8'($random(seed));
			host.pad(1'($random(seed)), 4'($random(seed)));
			host.wr(8'(a), m);
			if (a >= 3 && a <= 7) mreg[a] = m;
			rd_chk(8'(a));
			chk("sens", (mreg[4][2:0] == 3'h7) ? 8'h06 : 8'(mreg[4] & 7), {5'h00, sens_level});
			chk("rotary_on", 8'(mreg[3] & 1), {7'h00, rotary_on});
		end
		$display("register writes done");
		// reset in mid-run: every register back to zero
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		foreach (mreg[k]) mreg[k] = 0;
		for (i = 0; i < 7; i++) rd_chk(addrs[i]);
		chk("sens", 8'h00, {5'h00, sens_level});
		chk("rotary_on", 8'h00, {7'h00, rotary_on});
		$display("mid-run reset done");
		// six setup modes, sounder off then on, touch then release
		for (i = 0; i < 12; i++) begin
			m = modes[i % 6];
			host.wr(8'h03, m);
			host.wr(8'h07, 8'(i / 6));
			// touch alone, release alone, then both in one cycle
			for (n = 0; n < 3; n++) begin
				a = $unsigned($random(seed)) % 16;
				host.evt(n != 1, n != 0, 4'(a));
				// an admitted touch wins over a release in the same cycle
				v = m[0] & (((n != 1) & m[2]) | ((n != 0) & m[3]));
				chk("push", {7'h00, v}, {7'h00, fifo_push});
				if (v) chk("code", ((n != 1) & m[2]) ? {4'h1, 4'(a)} : 8'h0F, fifo_code);
				chk("click", {7'h00, m[0] & m[7] & (n != 1) & (i >= 6)}, {7'h00, click_req});
			end
		end
		$display("event gating done");
		// shortest tick with longest interval, then longest tick with a three-tick interval
		for (i = 0; i < 2; i++) begin
			host.wr(8'h03, 8'h00);
			host.wr(8'h05, i ? 8'hFF : 8'hE0);
			host.wr(8'h06, i ? 8'hC2 : 8'hFF);
			host.wr(8'h03, 8'h01);
			gap(1'b0, n);
			chk_n("tick_gap", (i ? 36 : 5) * CPM, n);
			gap(1'b1, n);
			chk_n("acq_gap", i ? 36 * CPM * 3 : 5 * CPM * 64, n);
		end
		$display("timebase done");
		close_out();
	end
endmodule
`default_nettype wire

/* dv/rtc_host_model.sv */
// host-side partner of the configuration bank: register strobes and pad events
// assumes the bank samples every input on the rising edge of clock
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
	input  wire logic       clock,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	output var  logic       touch_evt,
	output var  logic       release_evt,
	output var  logic       touch_held,
	output var  logic [3:0] touch_pos
);
	// idle values at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		touch_evt = 1'b0;
		release_evt = 1'b0;
		touch_held = 1'b0;
		touch_pos = 4'h0;
	end
	// one byte write; released bus shows the inverse so stale bytes never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// one byte read; answer taken in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
		v = reg_rvalid;
	endtask
	// one-cycle touch or release pulse; returns while the answer stands
	task automatic evt(input logic t, input logic r, input logic [3:0] p);
		@(posedge clock);
		touch_evt <= t;
		release_evt <= r;
		touch_pos <= p;
		@(posedge clock);
		touch_evt <= 1'b0;
		release_evt <= 1'b0;
		#1;
	endtask
	// pad level and position seen by the position register
	task automatic pad(input logic h, input logic [3:0] p);
		@(posedge clock);
		touch_held <= h;
		touch_pos <= p;
	endtask
endmodule
`default_nettype wire

/* rtl/rtc_config_regs.sv */
// rotary touch configuration register bank with event gating
// assumes the serial-bus slave in front decodes transfers into single-cycle
// byte read and write strobes on this clock, and the sensing front end
// reports touches and releases as same-clock one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs.svh"

// What this block does
// - setup bit 0 switches whole rotary function
// - touch bit lets touch codes into fifo
// - release bit lets release code into fifo
// - click bit lets touches trigger sounder
// - setup unused bits 6,5,4,1 read zero
// - setup writes keep only four defined bits
// - 3-bit sensitivity at 0x04, upper bits zero
// - tick period is 5 ms plus field
// - tick register upper bits read zero, ignored
// - acquisition every interval field plus one ticks
// - position reads zero unless touched and enabled
// - global sounder enable gates click requests
module rtc_config_regs #(
	parameter int CYC_PER_MS = `RTC_CYC_PER_MS  // cycles per ms, shorten in simulation
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       reg_wr,       // register write strobe
	input  wire logic       reg_rd,       // register read strobe
	input  wire logic [7:0] reg_addr,     // register address
	input  wire logic [7:0] reg_wdata,    // write data
	output var  logic [7:0] reg_rdata,    // read data
	output var  logic       reg_rvalid,   // read data valid, one cycle
	input  wire logic       touch_evt,    // new touch at touch_pos
	input  wire logic       release_evt,  // pad released
	input  wire logic       touch_held,   // a pad is currently touched
	input  wire logic [3:0] touch_pos,    // current position index
	output var  logic       fifo_push,    // push fifo_code into the event fifo
	output var  logic [7:0] fifo_code,    // event code
	output var  logic       click_req,    // one click request to the sounder
	output var  logic [2:0] sens_level,   // effective sensitivity code
	output var  logic       rotary_on,    // rotary function enabled
	output var  logic       tick_pulse,   // master tick strobe
	output var  logic       acq_pulse     // touch acquisition strobe
);

	rtc_pkg::rtc_state_t s_r;    // registered state
	rtc_pkg::rtc_state_t s_nxt;  // next state
	logic                wr_hit; // write strobe qualifier

	// timebase: runs only while the rotary is on
	rtc_timebase #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timebase (
		.clock      (clock),
		.resetn     (resetn),
		.run        (s_r.rot_en),
		.tick_field (s_r.tick),
		.intv_field (s_r.intv),
		.tick_pulse (tick_pulse),
		.acq_pulse  (acq_pulse)
	);

	// next-state logic: register writes, read answers, event gating
	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.push = 1'b0;
		s_nxt.click = 1'b0;
		wr_hit = reg_wr;

		// register writes; undefined bits are dropped on the way in
		if (wr_hit) begin
			case (reg_addr)
				`RTC_ADDR_SETUP: begin
					s_nxt.rot_en = reg_wdata[`RTC_SETUP_ENABLE];
					s_nxt.touch_en = reg_wdata[`RTC_SETUP_TOUCH];
					s_nxt.rel_en = reg_wdata[`RTC_SETUP_RELEASE];
					s_nxt.click_en = reg_wdata[`RTC_SETUP_CLICK];
				end
				`RTC_ADDR_SENS: begin
					s_nxt.sens = reg_wdata[2:0];
				end
				`RTC_ADDR_TICK: begin
					s_nxt.tick = reg_wdata[4:0];
				end
				`RTC_ADDR_INTERVAL: begin
					s_nxt.intv = reg_wdata[5:0];
				end
				`RTC_ADDR_SOUNDER: begin
					s_nxt.sound = reg_wdata[2:0];
				end
				// position register and unmapped addresses ignore writes
				default: begin
					s_nxt.sound = s_r.sound;
				end
			endcase
		end

		// read answers; every unused bit reads zero
		if (reg_rd) begin
			s_nxt.rvalid = 1'b1;
			case (reg_addr)
				`RTC_ADDR_POSITION: begin
					// released or disabled rotary reads all zero
					if (s_r.rot_en && touch_held) begin
						s_nxt.rdata = {3'h0, 1'b1, touch_pos};
					end else begin
						s_nxt.rdata = 8'h00;
					end
				end
				`RTC_ADDR_SETUP: begin
					s_nxt.rdata = {s_r.click_en, 3'h0, s_r.rel_en, s_r.touch_en, 1'b0, s_r.rot_en};
				end
				`RTC_ADDR_SENS: begin
					s_nxt.rdata = {5'h00, s_r.sens};
				end
				`RTC_ADDR_TICK: begin
					s_nxt.rdata = {3'h0, s_r.tick};
				end
				`RTC_ADDR_INTERVAL: begin
					s_nxt.rdata = {2'h0, s_r.intv};
				end
				`RTC_ADDR_SOUNDER: begin
					s_nxt.rdata = {5'h00, s_r.sound};
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end

		// event gating; an enabled touch wins if both arrive together, since the
		// fifo takes one code per cycle and the front end never does that
		if (s_r.rot_en) begin
			if (touch_evt && s_r.touch_en) begin
				s_nxt.push = 1'b1;
				s_nxt.code = {3'h0, 1'b1, touch_pos};
			end else if (release_evt && s_r.rel_en) begin
				s_nxt.push = 1'b1;
				s_nxt.code = `RTC_CODE_RELEASE;
			end
			// click needs both its own enable and the global sounder one
			s_nxt.click = touch_evt && s_r.click_en && s_r.sound[0];
		end

		// undefined code 111 behaves as the top level, stored value kept
		s_nxt.level = (s_r.sens == `RTC_SENS_UNDEF) ? `RTC_SENS_TOP : s_r.sens;
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.sens <= `RTC_RST_SENS;
			s_r.tick <= `RTC_RST_TICK;
			s_r.intv <= `RTC_RST_INTERVAL;
			s_r.sound <= `RTC_RST_SOUNDER;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = s_r.rdata;
	assign reg_rvalid = s_r.rvalid;
	assign fifo_push = s_r.push;
	assign fifo_code = s_r.code;
	assign click_req = s_r.click;
	assign sens_level = s_r.level;
	assign rotary_on = s_r.rot_en;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// a push only follows a cycle with the rotary on
	a_push_needs_en: assert property (fifo_push |-> $past(s_r.rot_en))
		else $error("fifo push while rotary disabled");
	a_touch_code: assert property (touch_evt && s_r.rot_en && s_r.touch_en
		|=> fifo_push && fifo_code == {3'h0, 1'b1, $past(touch_pos)})
		else $error("touch event not pushed with its code");
	a_touch_blocked: assert property (touch_evt && !s_r.touch_en && !release_evt |=> !fifo_push)
		else $error("touch pushed while touch report off");
	a_release_code: assert property (release_evt && !touch_evt && s_r.rot_en && s_r.rel_en
		|=> fifo_push && fifo_code == 8'h0F)
		else $error("release event not pushed as 0x0F");
	// the rotary enable is part of the click gate as well
	a_click_gate: assert property (click_req
		|-> $past(s_r.rot_en && s_r.click_en && s_r.sound[0] && touch_evt))
		else $error("click without touch and both enables");
	a_sound_off: assert property (!s_r.sound[0] |=> !click_req)
		else $error("click while sounder disabled");
	a_setup_zeros: assert property (reg_rd && reg_addr == 8'h03
		|=> reg_rvalid && reg_rdata[6:4] == 3'h0 && !reg_rdata[1])
		else $error("setup register unused bits not zero");
	a_setup_keep: assert property (reg_wr && reg_addr == 8'h03
		|=> s_r.rot_en == $past(reg_wdata[0]) && s_r.click_en == $past(reg_wdata[7]))
		else $error("setup write not stored");
	a_tick_upper: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata[7:5] == 3'h0)
		else $error("tick register upper bits not zero");
	a_sens_clamp: assert property (s_r.sens == 3'h7 |=> sens_level == 3'h6)
		else $error("undefined sensitivity code not clamped");
	a_pos_idle: assert property (reg_rd && reg_addr == 8'h02 && !(s_r.rot_en && touch_held)
		|=> reg_rdata == 8'h00)
		else $error("position not zero when idle");
	// touched and enabled position reads its index with bit 4 set
	a_pos_touched: assert property (reg_rd && reg_addr == 8'h02 && s_r.rot_en && touch_held
		|=> reg_rdata == {4'h1, $past(touch_pos)})
		else $error("touched position not reported");
	// a disabled rotary neither pushes nor clicks
	a_off_silent: assert property (!s_r.rot_en |=> !fifo_push && !click_req)
		else $error("event output while rotary disabled");
	// a release with its report bit clear stays out of the fifo
	a_rel_blocked: assert property (release_evt && !s_r.rel_en && !touch_evt |=> !fifo_push)
		else $error("release pushed while release report off");
	// an enabled touch with both sounder enables always clicks
	a_click_fire: assert property (touch_evt && s_r.rot_en && s_r.click_en && s_r.sound[0]
		|=> click_req)
		else $error("touch did not request a click");
	// sensitivity reads keep the upper bits zero
	a_sens_upper: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[7:3] == 5'h00)
		else $error("sensitivity register upper bits not zero");
	// tick writes keep exactly the low five bits
	a_tick_keep: assert property (reg_wr && reg_addr == 8'h05 |=> s_r.tick == $past(reg_wdata[4:0]))
		else $error("tick field not stored");
	// report bits of a setup write are kept too
	a_setup_flags: assert property (reg_wr && reg_addr == 8'h03
		|=> s_r.touch_en == $past(reg_wdata[2]) && s_r.rel_en == $past(reg_wdata[3]))
		else $error("setup report bits not stored");

endmodule
`default_nettype wire

/* rtl/rtc_timebase.sv */
// master tick and touch acquisition timebase
// assumes run, tick_field and intv_field come from flops on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_timebase #(
	parameter int CYC_PER_MS = `RTC_CYC_PER_MS  // cycles per ms, shorten in simulation
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       run,         // rotary function enabled
	input  wire logic [4:0] tick_field,  // tick period minus 5 ms
	input  wire logic [5:0] intv_field,  // ticks per acquisition minus one
	output var  logic       tick_pulse,  // one cycle per master tick
	output var  logic       acq_pulse    // one cycle per touch acquisition
);

	rtc_pkg::rtc_tb_state_t s_r;    // registered state
	rtc_pkg::rtc_tb_state_t s_nxt;  // next state
	logic [5:0] tick_len;           // tick length in ms

	// next-state logic; compares use >= so a field lowered mid-count cannot
	// strand the counter past its new end
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		s_nxt.acq = 1'b0;
		tick_len = 6'(`RTC_TICK_BASE_MS) + {1'b0, tick_field};
		if (!run) begin
			// disabled rotary: timebase held at its start
			s_nxt.ms_cnt = 18'h00000;
			s_nxt.ms_tick = 6'h00;
			s_nxt.ticks = 6'h00;
		end else if (s_r.ms_cnt >= 18'(CYC_PER_MS - 1)) begin
			s_nxt.ms_cnt = 18'h00000;
			if (s_r.ms_tick >= tick_len - 6'h01) begin
				// end of a master tick
				s_nxt.ms_tick = 6'h00;
				s_nxt.tick = 1'b1;
				if (s_r.ticks >= intv_field) begin
					s_nxt.ticks = 6'h00;
					s_nxt.acq = 1'b1;
				end else begin
					s_nxt.ticks = s_r.ticks + 6'h01;
				end
			end else begin
				s_nxt.ms_tick = s_r.ms_tick + 6'h01;
			end
		end else begin
			s_nxt.ms_cnt = s_r.ms_cnt + 18'h00001;
		end
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_pulse = s_r.tick;
	assign acq_pulse = s_r.acq;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// an acquisition only ever lands on a tick boundary
	a_acq_on_tick: assert property (acq_pulse |-> tick_pulse)
		else $error("acquisition strobe without tick strobe");
	// a stopped timebase stays silent
	a_idle_quiet: assert property (!run |=> !tick_pulse && !acq_pulse)
		else $error("timebase pulsed while rotary disabled");

endmodule
`default_nettype wire
